// >>> design/tdsio_defines.vh
`ifndef TDSIO_DEFINES_VH
`define TDSIO_DEFINES_VH

// Microsecond tick from the 100 MHz clock
`define TDSIO_CLK_MHZ        100
`define TDSIO_US_DIV         (`TDSIO_CLK_MHZ - 1)
`define TDSIO_DIV_W          7
`define TDSIO_FILT_W         8
`define TDSIO_FILT_MIN       8'h01
`define TDSIO_NUM_IN         4
`define TDSIO_NUM_OUT        8
`define TDSIO_DLY_W          16

// Trigger input select codes
`define TDSIO_SEL_IN1        2'h0
`define TDSIO_SEL_IN2        2'h1
`define TDSIO_SEL_BOTH       2'h2

// Flash method codes
`define TDSIO_FM_EVERY       1'b0
`define TDSIO_FM_ONCE        1'b1

// Flash states
`define TDSIO_FS_IDLE        2'h0
`define TDSIO_FS_DELAY       2'h1
`define TDSIO_FS_PULSE       2'h2

`endif

// >>> design/tdsio_filter.v
`timescale 1ns/100ps
`default_nettype none
`include "tdsio_defines.vh"

// Passes a level only after it has held for limit plus one microsecond ticks
module tdsio_filter (
    input  wire                     clk,
    input  wire                     rst,
    input  wire                     tick_us,
    input  wire [`TDSIO_FILT_W-1:0] filt_time,
    input  wire                     raw_in,
    output reg                      clean_q
);
    reg [`TDSIO_FILT_W-1:0] cnt_q;
    wire [`TDSIO_FILT_W-1:0] limit;

    // Zero programmed acts as one microsecond
    assign limit = (filt_time == 8'h00) ? `TDSIO_FILT_MIN : filt_time;

    always @(posedge clk) begin
        if (rst) begin
            cnt_q   <= 8'h00;
            clean_q <= 1'b0;
        end else if (raw_in == clean_q) begin
            cnt_q <= 8'h00;
        end else if (tick_us) begin
            // One extra tick: the first may land anywhere in a microsecond
            if (cnt_q >= limit) begin
                clean_q <= raw_in;
                cnt_q   <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule // tdsio_filter

`default_nettype wire

// >>> design/tdsio_top.v
// Summary of operation
// - Four inputs, each readable with own interrupt
// - Inputs 1 and 2 selectable as triggers
// - Trigger debounce programmable 1 to 255 us
// - Pulses shorter than debounce are dropped
// - Debounce value zero acts as 1 us
// - Trigger needs input held past debounce
// - Software trigger equals validated external trigger
// - Input 2 ends frame in two-pulse mode
// - Output 1 from software value or strobe
// - Outputs tri-stated until software enables each
`timescale 1ns/100ps
`default_nettype none
`include "tdsio_defines.vh"

module tdsio_top (
    // Clock and reset
    input  wire                      CLK_IN,
    input  wire                      SYS_RST_IN,
    // General inputs from isolators
    input  wire [`TDSIO_NUM_IN-1:0]  GEN_IN,
    // Trigger configuration
    input  wire                      EXT_TRIGGER_ON_IN,
    input  wire [1:0]                TRIGGER_INPUT_SELECT_IN,
    input  wire [1:0]                TRIGGER_EDGE_SELECT_IN,
    input  wire [`TDSIO_FILT_W-1:0]  TRIGGER_FILTER_TIME_IN,
    input  wire                      TWO_PULSE_MODE_IN,
    input  wire                      SW_TRIGGER_IN,
    // Output control
    input  wire [`TDSIO_NUM_OUT-1:0] OUT_VALUE_IN,
    input  wire [`TDSIO_NUM_OUT-1:0] OUT_ENABLE_IN,
    // Strobe configuration
    input  wire                      FLASH_PULSE_ON_IN,
    input  wire                      FLASH_PULSE_POLARITY_IN,
    input  wire                      FLASH_PULSE_METHOD_IN,
    input  wire [`TDSIO_DLY_W-1:0]   FLASH_PULSE_DELAY_IN,
    input  wire [`TDSIO_DLY_W-1:0]   FLASH_PULSE_WIDTH_IN,
    input  wire                      FLASH_REARM_IN,
    // Status and events
    output reg  [`TDSIO_NUM_IN-1:0]  GEN_IN_STATE_OUT,
    output reg  [`TDSIO_NUM_IN-1:0]  GEN_IN_EVENT_OUT,
    output reg                       ACQ_TRIGGER_OUT,
    output reg                       FRAME_END_OUT,
    // General output pins
    output reg  [`TDSIO_NUM_OUT-1:0] GEN_OUT,
    output reg  [`TDSIO_NUM_OUT-1:0] GEN_OUT_OE_N_OUT
);
    reg [`TDSIO_DIV_W-1:0] div_q;
    reg                    tick_q;
    reg [1:0]              clean_d1_q;
    reg [`TDSIO_NUM_IN-1:0] in_d1_q;
    reg [1:0]              fs_q;
    reg [`TDSIO_DLY_W-1:0] fcnt_q;
    reg                    fire_q;
    reg                    done_once_q;
    wire [1:0]             clean;
    wire [1:0]             rise;
    wire [1:0]             fall;
    wire [1:0]             hit;
    wire                   use1;
    wire                   use2;
    wire                   ext_trig;
    wire                   trig;
    wire                   end_pulse;
    wire [`TDSIO_NUM_OUT-1:0] pin_val;

    // Microsecond time base
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            div_q  <= 7'h00;
            tick_q <= 1'b0;
        end else if (div_q == `TDSIO_US_DIV) begin
            div_q  <= 7'h00;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 7'h01;
            tick_q <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
            tdsio_filter u_filt (
                .clk       (CLK_IN),
                .rst       (SYS_RST_IN),
                .tick_us   (tick_q),
                .filt_time (TRIGGER_FILTER_TIME_IN),
                .raw_in    (GEN_IN[gi]),
                .clean_q   (clean[gi])
            );
        end
    endgenerate

    assign rise = clean & ~clean_d1_q;
    assign fall = ~clean & clean_d1_q;
    // Edge select bit high picks the falling edge
    assign hit  = (rise & ~TRIGGER_EDGE_SELECT_IN) |
                  (fall & TRIGGER_EDGE_SELECT_IN);
    assign use1 = (TRIGGER_INPUT_SELECT_IN == `TDSIO_SEL_IN1) ||
                  (TRIGGER_INPUT_SELECT_IN == `TDSIO_SEL_BOTH);
    assign use2 = ((TRIGGER_INPUT_SELECT_IN == `TDSIO_SEL_IN2) ||
                  (TRIGGER_INPUT_SELECT_IN == `TDSIO_SEL_BOTH)) &&
                  !TWO_PULSE_MODE_IN;
    assign ext_trig = EXT_TRIGGER_ON_IN &&
                      ((hit[0] && use1) || (hit[1] && use2));
    assign trig = ext_trig || SW_TRIGGER_IN;
    // In two-pulse mode input 2 closes the frame rather than opening one
    assign end_pulse = EXT_TRIGGER_ON_IN && TWO_PULSE_MODE_IN && hit[1];

    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            clean_d1_q       <= 2'h0;
            in_d1_q          <= 4'h0;
            GEN_IN_STATE_OUT <= 4'h0;
            GEN_IN_EVENT_OUT <= 4'h0;
            ACQ_TRIGGER_OUT  <= 1'b0;
            FRAME_END_OUT    <= 1'b0;
        end else begin
            clean_d1_q       <= clean;
            in_d1_q          <= GEN_IN;
            GEN_IN_STATE_OUT <= GEN_IN;
            GEN_IN_EVENT_OUT <= GEN_IN ^ in_d1_q;
            ACQ_TRIGGER_OUT  <= trig;
            FRAME_END_OUT    <= end_pulse;
        end
    end

    // Strobe generator; once method fires a single time, then not again until rearmed
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            fs_q        <= `TDSIO_FS_IDLE;
            fcnt_q      <= 16'h0000;
            fire_q      <= 1'b0;
            done_once_q <= 1'b0;
        end else begin
            if (FLASH_REARM_IN)
                done_once_q <= 1'b0;
            case (fs_q)
                `TDSIO_FS_IDLE: begin
                    fire_q <= 1'b0;
                    fcnt_q <= 16'h0000;
                    if (trig && FLASH_PULSE_ON_IN &&
                        !(FLASH_PULSE_METHOD_IN == `TDSIO_FM_ONCE &&
                          done_once_q)) begin
                        fs_q        <= `TDSIO_FS_DELAY;
                        done_once_q <= 1'b1;
                    end
                end
                `TDSIO_FS_DELAY: begin
                    if (!FLASH_PULSE_ON_IN) begin
                        fs_q <= `TDSIO_FS_IDLE;
                    end else if (tick_q) begin
                        if (fcnt_q >= FLASH_PULSE_DELAY_IN) begin
                            fs_q   <= `TDSIO_FS_PULSE;
                            fire_q <= 1'b1;
                            fcnt_q <= 16'h0000;
                        end else begin
                            fcnt_q <= fcnt_q + 16'h0001;
                        end
                    end
                end
                `TDSIO_FS_PULSE: begin
                    if (!FLASH_PULSE_ON_IN) begin
                        fs_q   <= `TDSIO_FS_IDLE;
                        fire_q <= 1'b0;
                    end else if (tick_q) begin
                        // Width zero still gives one microsecond
                        if (fcnt_q + 16'h0001 >= FLASH_PULSE_WIDTH_IN) begin
                            fs_q   <= `TDSIO_FS_IDLE;
                            fire_q <= 1'b0;
                        end else begin
                            fcnt_q <= fcnt_q + 16'h0001;
                        end
                    end
                end
                default: begin
                    fs_q   <= `TDSIO_FS_IDLE;
                    fire_q <= 1'b0;
                end
            endcase
        end
    end

    assign pin_val = {OUT_VALUE_IN[`TDSIO_NUM_OUT-1:1],
                      FLASH_PULSE_ON_IN ?
                      (fire_q ^ FLASH_PULSE_POLARITY_IN) :
                      OUT_VALUE_IN[0]};

    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            GEN_OUT          <= 8'h00;
            GEN_OUT_OE_N_OUT <= 8'hff;
        end else begin
            GEN_OUT          <= pin_val;
            GEN_OUT_OE_N_OUT <= ~OUT_ENABLE_IN;
        end
    end
endmodule // tdsio_top

`default_nettype wire

// >>> testbench/tdsio_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module tdsio_chk (
    input wire logic       CLK_IN, SYS_RST_IN, SW_TRIGGER_IN, EXT_TRIGGER_ON_IN,
    input wire logic       TWO_PULSE_MODE_IN, FLASH_PULSE_ON_IN,
    input wire logic       ACQ_TRIGGER_OUT, FRAME_END_OUT,
    input wire logic [1:0] TRIGGER_INPUT_SELECT_IN,
    input wire logic [3:0] GEN_IN, GEN_IN_STATE_OUT, GEN_IN_EVENT_OUT,
    input wire logic [7:0] TRIGGER_FILTER_TIME_IN, OUT_VALUE_IN, OUT_ENABLE_IN,
    input wire logic [7:0] GEN_OUT, GEN_OUT_OE_N_OUT
);
    logic [3:0]  age_q;
    logic [15:0] calm_q;
    logic        g0_q;
    wire  [15:0] need = (TRIGGER_FILTER_TIME_IN == 8'h00) ? 16'h0064 :
                        16'h0064 * {8'h00, TRIGGER_FILTER_TIME_IN};
    wire  [7:0]  en = OUT_ENABLE_IN;
    // Quiet time of input 1, the only bound on how early a trigger may come
    always_ff @(posedge CLK_IN) begin
        age_q  <= SYS_RST_IN ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
        g0_q   <= GEN_IN[0];
        calm_q <= (SYS_RST_IN || GEN_IN[0] != g0_q) ? 16'h0000 :
                  calm_q + {15'h0000, calm_q != 16'hffff};
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    chk_state_copy: assert property ((age_q > 4'h4 && $stable(GEN_IN)) [*4]
        |-> GEN_IN_STATE_OUT == GEN_IN) else $error("input state wrong");
    chk_event_quiet: assert property ((age_q > 4'h4 && $stable(GEN_IN)) [*4]
        |-> GEN_IN_EVENT_OUT == 4'h0) else $error("event without change");
    chk_oe_follow: assert property ((age_q > 4'h2 && $stable(en)) [*2]
        |-> GEN_OUT_OE_N_OUT == ~en) else $error("output enable wrong");
    chk_out_value: assert property ((age_q > 4'h2 &&
        $stable({OUT_VALUE_IN, en, FLASH_PULSE_ON_IN})) [*2] |->
        (GEN_OUT & en & {7'h7f, !FLASH_PULSE_ON_IN}) ==
        (OUT_VALUE_IN & en & {7'h7f, !FLASH_PULSE_ON_IN}))
        else $error("output value wrong");
    chk_sw_trig: assert property (SW_TRIGGER_IN |=> ACQ_TRIGGER_OUT)
        else $error("software trigger lost");
    chk_trig_cause: assert property (ACQ_TRIGGER_OUT && !$past(SW_TRIGGER_IN)
        |-> $past(EXT_TRIGGER_ON_IN) && $past(TRIGGER_INPUT_SELECT_IN) != 2'h3)
        else $error("trigger without source");
    chk_filter_hold: assert property (ACQ_TRIGGER_OUT && !$past(SW_TRIGGER_IN) &&
        TRIGGER_INPUT_SELECT_IN == 2'h0 |-> calm_q >= need)
        else $error("trigger before debounce");
    chk_frame_mode: assert property (FRAME_END_OUT |-> $past(TWO_PULSE_MODE_IN))
        else $error("frame end outside mode");
    cover property (ACQ_TRIGGER_OUT && !$past(SW_TRIGGER_IN));
    cover property (FRAME_END_OUT);
    cover property ($changed(GEN_OUT[0]) && FLASH_PULSE_ON_IN);
endmodule // tdsio_chk
bind tdsio_top tdsio_chk u_chk (.*);
`default_nettype wire

// >>> testbench/tdsio_field_model.sv
`timescale 1ns/100ps
`default_nettype none
module tdsio_field_model (
    input  wire logic        clk,
    input  wire logic        fire,
    input  wire logic [1:0]  line,
    input  wire logic [15:0] width,
    output logic      [3:0]  lines
);
    logic [15:0] left_q;
    initial {lines, left_q} = '0;
    // Source holds its level the full width, past isolator and debounce
    always @(negedge clk) begin
        if (fire) begin
            lines[line] <= 1'b1;
            left_q      <= width;
        end else if (left_q > 16'h0001) begin
            left_q <= left_q - 16'h0001;
        end else begin
            lines  <= 4'h0;
            left_q <= 16'h0000;
        end
    end
endmodule // tdsio_field_model
`default_nettype wire

// >>> testbench/tdsio_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tdsio_tb_top;
    logic CLK_IN, SYS_RST_IN, EXT_TRIGGER_ON_IN, TWO_PULSE_MODE_IN, fire;
    logic SW_TRIGGER_IN, FLASH_PULSE_ON_IN, FLASH_PULSE_POLARITY_IN;
    logic FLASH_PULSE_METHOD_IN, FLASH_REARM_IN, ACQ_TRIGGER_OUT, FRAME_END_OUT;
    logic [1:0]  TRIGGER_INPUT_SELECT_IN, TRIGGER_EDGE_SELECT_IN, line;
    logic [3:0]  GEN_IN, GEN_IN_STATE_OUT, GEN_IN_EVENT_OUT;
    logic [7:0]  TRIGGER_FILTER_TIME_IN, OUT_VALUE_IN, OUT_ENABLE_IN;
    logic [7:0]  GEN_OUT, GEN_OUT_OE_N_OUT;
    logic [15:0] FLASH_PULSE_DELAY_IN, FLASH_PULSE_WIDTH_IN, width;
    logic [15:0] n_acq, n_end, n_fl, n_ev, cyc;
    int          err_total, n_compared;
    tdsio_top u_dut (.*);
    tdsio_field_model u_src (.clk(CLK_IN), .fire(fire), .line(line),
                             .width(width), .lines(GEN_IN));
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One trigger from software or the field source, then a quiet window
    task automatic go(input logic sw, input logic [1:0] l,
                      input logic [15:0] w, input int n);
        @(negedge CLK_IN);
        {n_acq, n_end, n_fl, n_ev} = '0;
        line <= l;
        width <= w;
        if (sw) SW_TRIGGER_IN <= 1'b1;
        else fire <= 1'b1;
        @(negedge CLK_IN);
        {SW_TRIGGER_IN, fire} <= 2'h0;
        repeat (n) @(negedge CLK_IN);
    endtask
    always @(posedge CLK_IN) begin
        cyc <= cyc + 16'h0001;
        n_acq <= n_acq + 16'(ACQ_TRIGGER_OUT);
        n_end <= n_end + 16'(FRAME_END_OUT);
        n_fl <= n_fl + 16'(GEN_OUT[0] ^ FLASH_PULSE_POLARITY_IN);
        n_ev <= n_ev + 16'($countones(GEN_IN_EVENT_OUT));
        if (cyc == 16'h7530) begin
            err_total++;
            wrap_up;
        end
    end
    initial begin
        CLK_IN = 1'b0;
        forever #5 CLK_IN = ~CLK_IN;
    end
    initial begin
        {EXT_TRIGGER_ON_IN, TWO_PULSE_MODE_IN, fire, SW_TRIGGER_IN} = '0;
        {FLASH_PULSE_ON_IN, FLASH_PULSE_POLARITY_IN, FLASH_PULSE_METHOD_IN} = '0;
        {FLASH_REARM_IN, TRIGGER_INPUT_SELECT_IN, TRIGGER_EDGE_SELECT_IN} = '0;
        {line, TRIGGER_FILTER_TIME_IN, OUT_VALUE_IN, OUT_ENABLE_IN} = '0;
        {FLASH_PULSE_DELAY_IN, FLASH_PULSE_WIDTH_IN, width, cyc} = '0;
        {n_acq, n_end, n_fl, n_ev, err_total, n_compared} = '0;
        SYS_RST_IN = 1'b1;
        repeat (12) @(negedge CLK_IN);
        SYS_RST_IN = 1'b0;
        check(GEN_OUT_OE_N_OUT, 8'hff);
        OUT_ENABLE_IN = 8'h0f;
        OUT_VALUE_IN = 8'h5a;
        repeat (3) @(negedge CLK_IN);
        check(GEN_OUT_OE_N_OUT, 8'hf0);
        check(GEN_OUT & 8'h0f, 8'h0a);
        for (int i = 0; i < 4; i++) begin
            go(1'b0, 2'(i), 16'h0005, 2);
            check(GEN_IN_STATE_OUT, 16'h0001 << i);
            repeat (8) @(negedge CLK_IN);
            check(n_ev, 16'h0002);
            check(n_acq, 16'h0000);
        end
        EXT_TRIGGER_ON_IN = 1'b1;
        TRIGGER_FILTER_TIME_IN = 8'h03;
        go(1'b0, 2'h0, 16'd250, 600); check(n_acq, 16'h0000);
        go(1'b0, 2'h0, 16'd500, 800); check(n_acq, 16'h0001);
        TRIGGER_FILTER_TIME_IN = 8'h00;
        go(1'b0, 2'h0, 16'd80, 300); check(n_acq, 16'h0000);
        go(1'b0, 2'h0, 16'd250, 500); check(n_acq, 16'h0001);
        TRIGGER_EDGE_SELECT_IN = 2'h1;
        go(1'b0, 2'h0, 16'd250, 300); check(n_acq, 16'h0000);
        repeat (300) @(negedge CLK_IN); check(n_acq, 16'h0001);
        TRIGGER_EDGE_SELECT_IN = 2'h0;
        TRIGGER_INPUT_SELECT_IN = 2'h1;
        go(1'b0, 2'h1, 16'd250, 500); check(n_acq, 16'h0001);
        go(1'b0, 2'h0, 16'd250, 500); check(n_acq, 16'h0000);
        TRIGGER_INPUT_SELECT_IN = 2'h2;
        go(1'b0, 2'h0, 16'd250, 500); check(n_acq, 16'h0001);
        TRIGGER_INPUT_SELECT_IN = 2'h3;
        go(1'b0, 2'h1, 16'd250, 500); check(n_acq, 16'h0000);
        TRIGGER_INPUT_SELECT_IN = 2'h1;
        EXT_TRIGGER_ON_IN = 1'b0;
        go(1'b0, 2'h1, 16'd250, 500); check(n_acq, 16'h0000);
        EXT_TRIGGER_ON_IN = 1'b1;
        TWO_PULSE_MODE_IN = 1'b1;
        go(1'b0, 2'h1, 16'd250, 500); check(n_end, 16'h0001);
        check(n_acq, 16'h0000);
        TWO_PULSE_MODE_IN = 1'b0;
        go(1'b1, 2'h0, 16'h0000, 3); check(n_acq, 16'h0001);
        FLASH_PULSE_ON_IN = 1'b1;
        FLASH_PULSE_DELAY_IN = 16'h0002;
        FLASH_PULSE_WIDTH_IN = 16'h0003;
        go(1'b1, 2'h0, 16'h0000, 150); check(n_fl, 16'h0000);
        repeat (650) @(negedge CLK_IN); check(n_fl, 16'd300);
        FLASH_PULSE_POLARITY_IN = 1'b1;
        go(1'b1, 2'h0, 16'h0000, 800); check(n_fl, 16'd300);
        FLASH_PULSE_METHOD_IN = 1'b1;
        FLASH_REARM_IN = 1'b1;
        @(negedge CLK_IN);
        FLASH_REARM_IN = 1'b0;
        go(1'b1, 2'h0, 16'h0000, 800); check(n_fl, 16'd300);
        go(1'b1, 2'h0, 16'h0000, 800); check(n_fl, 16'h0000);
        wrap_up;
    end
endmodule // tdsio_tb_top
`default_nettype wire
